// File: shared/seprd_pkg.sv
// constants and types shared by the serial eeprom read and pause logic
package seprd_pkg;
  // instruction codes
  localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS    = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;
  // status byte layout
  localparam int unsigned ST_PROTECT_PIN_EN = 7;
  localparam int unsigned ST_BP_HIGH        = 3;
  localparam int unsigned ST_BP_LOW         = 2;
  localparam int unsigned ST_WR_EN_LATCH    = 1;
  localparam int unsigned ST_BUSY           = 0;
  localparam logic [7:0]  STATUS_WR_MASK    = 8'h8C;
  localparam logic [7:0]  STATUS_RESET      = 8'h00;
  // framing
  localparam int unsigned ARRAY_ADDR_BITS = 13;
  localparam logic [4:0]  OPCODE_LAST_BIT = 5'h07;
  localparam logic [4:0]  ADDR_LAST_BIT   = 5'h17;
  // self-timed write cycle
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned WRITE_TIME_NS   = 5000000;
  localparam int unsigned WRITE_CYCLES    = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // buffer depth between array and shifter
  localparam int unsigned BUF_DEPTH       = 2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_READ, ST_STAT, ST_WEN, ST_WSR, ST_WR, ST_IGNORE
  } seprd_state_t;
endpackage

// File: design/seprd_core.sv
// serial eeprom read, status read, pause and write-cycle start logic
//
// Summary of operation
// - data starts right after last address bit
// - continued clocking streams consecutive bytes
// - pointer advances one location per byte
// - pointer wraps from top location to zero
// - select high ends read, releases output
// - status byte follows status read opcode
// - status read answered even while busy
// - paused: output released, input ignored, position kept
// - reset holds device, release enters standby
// - reset clears write enable, enters standby
// - finished write clears write enable latch
// - select rising edge starts write cycle
// - busy device ignores array commands
// - unknown opcode ignored, output stays released
// - six fixed opcode encodings decoded
// - status layout: enable, zeros, protect, latch, busy
// - only low 13 address bits used
// - input sampled on rising serial clock
`timescale 1ns/10ps
module seprd_core #(
  parameter int unsigned ADDR_BITS    = seprd_pkg::ARRAY_ADDR_BITS,
  parameter int unsigned WRITE_CYCLES = seprd_pkg::WRITE_CYCLES
) (
  input  wire logic ref_clk,     // system clock, 125 MHz
  input  wire logic srst,        // power-on reset, sync, active high
  input  wire logic cs_n_pin,    // chip select, active low
  input  wire logic sck_pin,     // serial clock from host
  input  wire logic si_pin,      // serial data in
  input  wire logic hold_n_pin,  // pause input, active low
  output logic      so_out,      // serial data out value
  output logic      so_oe,       // serial data out enable
  output logic      busy,        // internal write cycle running
  output logic      write_enable_latch // write enable latch
);
  localparam int unsigned TW = $clog2(WRITE_CYCLES + 1);
  localparam logic [ADDR_BITS-1:0] TOP_ADDR = {ADDR_BITS{1'b1}};

  generate
    if (ADDR_BITS < 2 || ADDR_BITS > 16 || WRITE_CYCLES < 1)
    begin : g_bad_param
      $error("seprd_core: unsupported parameter values");
    end
  endgenerate

  // pin synchronisers; the third stage is only the edge history
  logic [2:0] cs_sync_reg, sck_sync_reg;
  logic [1:0] si_sync_reg, hold_sync_reg;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cs_sync_reg   <= 3'h7;
      sck_sync_reg  <= 3'h0;
      si_sync_reg   <= 2'h0;
      hold_sync_reg <= 2'h3;
    end
    else
    begin
      cs_sync_reg   <= {cs_sync_reg[1:0], cs_n_pin};
      sck_sync_reg  <= {sck_sync_reg[1:0], sck_pin};
      si_sync_reg   <= {si_sync_reg[0], si_pin};
      hold_sync_reg <= {hold_sync_reg[0], hold_n_pin};
    end
  end

  logic cs_n_s, sck_s, si_s, hold_n_s, cs_rise, cs_fall;
  assign cs_n_s   = cs_sync_reg[1];
  assign sck_s    = sck_sync_reg[1];
  assign si_s     = si_sync_reg[1];
  assign hold_n_s = hold_sync_reg[1];
  assign cs_rise  = cs_sync_reg[1] & ~cs_sync_reg[2];
  assign cs_fall  = ~cs_sync_reg[1] & cs_sync_reg[2];

  // pause: entered only while the clock is low, left with the clock low or at once on deselect
  logic held_reg;
  always_ff @(posedge ref_clk)
  begin
    if (srst || cs_n_s)
      held_reg <= 1'b0;
    else if (!sck_s)
      held_reg <= ~hold_n_s;
  end

  // edges are swallowed while paused so the bit position survives
  logic sck_rise, sck_fall;
  assign sck_rise = sck_s & ~sck_sync_reg[2] & ~held_reg & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_sync_reg[2] & ~held_reg & ~cs_n_s;

  // state and framing counters
  seprd_pkg::seprd_state_t state_reg, state_next;
  logic [4:0] in_cnt_reg;
  logic [2:0] bit_pos_reg;
  logic [7:0] in_sr_reg;
  logic [7:0] in_byte;
  logic [15:0] addr_sr_reg;
  logic [7:0] opcode_reg;
  logic       byte_got_reg;
  logic [7:0] wr_data_reg;
  logic       wr_busy_reg;
  logic [7:0] status_nv_reg;
  logic       write_enable_latch_reg;

  assign in_byte = {in_sr_reg[6:0], si_s};

  logic op_done, addr_done, byte_done, op_valid;
  assign op_done   = sck_rise && state_reg == seprd_pkg::ST_CMD
                     && in_cnt_reg == seprd_pkg::OPCODE_LAST_BIT;
  assign addr_done = sck_rise && state_reg == seprd_pkg::ST_ADDR
                     && in_cnt_reg == seprd_pkg::ADDR_LAST_BIT;
  assign byte_done = sck_rise && bit_pos_reg == 3'h7;
  assign op_valid  = in_byte == seprd_pkg::OP_ARRAY_READ   || in_byte == seprd_pkg::OP_STATUS_READ
                  || in_byte == seprd_pkg::OP_WRITE_ENABLE || in_byte == seprd_pkg::OP_WRITE_DIS
                  || in_byte == seprd_pkg::OP_STATUS_WRITE || in_byte == seprd_pkg::OP_ARRAY_WRITE;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      seprd_pkg::ST_IDLE:
        if (cs_fall)
          state_next = seprd_pkg::ST_CMD;
      seprd_pkg::ST_CMD:
        if (op_done)
        begin
          if (!op_valid)
            state_next = seprd_pkg::ST_IGNORE;
          else if (in_byte == seprd_pkg::OP_STATUS_READ)
            state_next = seprd_pkg::ST_STAT;
          else if (wr_busy_reg)
            state_next = seprd_pkg::ST_IGNORE;
          else if (in_byte == seprd_pkg::OP_ARRAY_READ || in_byte == seprd_pkg::OP_ARRAY_WRITE)
            state_next = seprd_pkg::ST_ADDR;
          else if (in_byte == seprd_pkg::OP_STATUS_WRITE)
            state_next = seprd_pkg::ST_WSR;
          else
            state_next = seprd_pkg::ST_WEN;
        end
      seprd_pkg::ST_ADDR:
        if (addr_done)
          state_next = opcode_reg == seprd_pkg::OP_ARRAY_READ ? seprd_pkg::ST_READ
                                                              : seprd_pkg::ST_WR;
      seprd_pkg::ST_WEN:
        if (sck_rise)
          state_next = seprd_pkg::ST_IGNORE;
      seprd_pkg::ST_WSR:
        if (sck_rise && byte_got_reg)
          state_next = seprd_pkg::ST_IGNORE;
      seprd_pkg::ST_READ, seprd_pkg::ST_STAT, seprd_pkg::ST_WR, seprd_pkg::ST_IGNORE:
        state_next = state_reg;
      default:
        state_next = seprd_pkg::ST_IDLE;
    endcase
    if (cs_n_s)
      state_next = seprd_pkg::ST_IDLE;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      state_reg <= seprd_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  // input shifting, sampled on rising serial clock
  always_ff @(posedge ref_clk)
  begin
    if (srst || cs_n_s)
    begin
      in_cnt_reg   <= 5'h00;
      bit_pos_reg  <= 3'h0;
      in_sr_reg    <= 8'h00;
      byte_got_reg <= 1'b0;
    end
    else if (sck_rise)
    begin
      in_sr_reg <= in_byte;
      if (state_reg == seprd_pkg::ST_CMD || state_reg == seprd_pkg::ST_ADDR)
        in_cnt_reg <= in_cnt_reg + 5'h01;
      else
        bit_pos_reg <= bit_pos_reg + 3'h1;
      if (byte_done && state_reg != seprd_pkg::ST_CMD && state_reg != seprd_pkg::ST_ADDR)
        byte_got_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      opcode_reg  <= 8'h00;
      addr_sr_reg <= 16'h0000;
      wr_data_reg <= 8'h00;
    end
    else
    begin
      if (op_done)
        opcode_reg <= in_byte;
      if (sck_rise && state_reg == seprd_pkg::ST_ADDR)
        addr_sr_reg <= {addr_sr_reg[14:0], si_s};
      if (byte_done && !byte_got_reg
          && (state_reg == seprd_pkg::ST_WR || state_reg == seprd_pkg::ST_WSR))
        wr_data_reg <= in_byte;
    end
  end

  // array; only the first loaded byte of a write is programmed here
  logic [7:0] mem [2**ADDR_BITS];
  logic [ADDR_BITS-1:0] fetch_ptr_reg;
  logic [ADDR_BITS-1:0] wr_addr_reg;
  logic [TW-1:0]        wr_timer_reg;
  logic                 wr_is_array_reg;
  logic                 wr_start, wr_finish;

  // select rising after a whole frame is what launches programming
  assign wr_start = cs_rise && write_enable_latch_reg && byte_got_reg && bit_pos_reg == 3'h0
                    && (state_reg == seprd_pkg::ST_WR || state_reg == seprd_pkg::ST_WSR);
  assign wr_finish = wr_busy_reg && wr_timer_reg == TW'(1);

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      wr_busy_reg     <= 1'b0;
      wr_timer_reg    <= '0;
      wr_is_array_reg <= 1'b0;
      wr_addr_reg     <= '0;
    end
    else if (wr_start)
    begin
      wr_busy_reg     <= 1'b1;
      wr_timer_reg    <= TW'(WRITE_CYCLES);
      wr_is_array_reg <= state_reg == seprd_pkg::ST_WR;
      wr_addr_reg     <= addr_sr_reg[ADDR_BITS-1:0];
    end
    else if (wr_busy_reg)
    begin
      wr_timer_reg <= wr_timer_reg - TW'(1);
      if (wr_finish)
        wr_busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (wr_finish && wr_is_array_reg)
      mem[wr_addr_reg] <= wr_data_reg;
  end

  // write enable latch and non-volatile status bits
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      write_enable_latch_reg <= 1'b0;
      status_nv_reg          <= seprd_pkg::STATUS_RESET;
    end
    else
    begin
      if (wr_finish)
        write_enable_latch_reg <= 1'b0;
      else if (cs_rise && state_reg == seprd_pkg::ST_WEN)
        write_enable_latch_reg <= opcode_reg == seprd_pkg::OP_WRITE_ENABLE;
      if (wr_finish && !wr_is_array_reg)
        status_nv_reg <= wr_data_reg & seprd_pkg::STATUS_WR_MASK;
    end
  end

  logic [7:0] status_byte;
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[seprd_pkg::ST_PROTECT_PIN_EN] = status_nv_reg[seprd_pkg::ST_PROTECT_PIN_EN];
    status_byte[seprd_pkg::ST_BP_HIGH] = status_nv_reg[seprd_pkg::ST_BP_HIGH];
    status_byte[seprd_pkg::ST_BP_LOW]  = status_nv_reg[seprd_pkg::ST_BP_LOW];
    status_byte[seprd_pkg::ST_WR_EN_LATCH] = write_enable_latch_reg;
    status_byte[seprd_pkg::ST_BUSY]    = wr_busy_reg;
  end

  // two-entry buffer between array and shifter; fetch stalls when full
  logic [7:0] buf_mem [seprd_pkg::BUF_DEPTH];
  logic       buf_wr_ptr_reg, buf_rd_ptr_reg;
  logic [1:0] buf_cnt_reg;
  logic       push_valid, push_ready, pop_valid, pop_ready, push, pop;
  logic       flush;

  assign flush      = addr_done || state_reg != seprd_pkg::ST_READ;
  assign push_valid = state_reg == seprd_pkg::ST_READ;
  assign push_ready = buf_cnt_reg != 2'(seprd_pkg::BUF_DEPTH);
  assign pop_valid  = buf_cnt_reg != 2'h0;
  assign pop_ready  = sck_fall && bit_pos_reg == 3'h0 && state_reg == seprd_pkg::ST_READ;
  assign push       = push_valid && push_ready && !flush;
  assign pop        = pop_valid && pop_ready && !flush;

  always_ff @(posedge ref_clk)
  begin
    if (srst || flush)
    begin
      buf_wr_ptr_reg <= 1'b0;
      buf_rd_ptr_reg <= 1'b0;
      buf_cnt_reg    <= 2'h0;
    end
    else
    begin
      if (push)
        buf_wr_ptr_reg <= ~buf_wr_ptr_reg;
      if (pop)
        buf_rd_ptr_reg <= ~buf_rd_ptr_reg;
      buf_cnt_reg <= buf_cnt_reg + 2'(push) - 2'(pop);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (push)
      buf_mem[buf_wr_ptr_reg] <= mem[fetch_ptr_reg];
  end

  // pointer moves once per byte handed to the shifter path
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      fetch_ptr_reg <= '0;
    else if (addr_done)
      fetch_ptr_reg <= {addr_sr_reg[ADDR_BITS-2:0], si_s};
    else if (push)
      fetch_ptr_reg <= fetch_ptr_reg + ADDR_BITS'(1);
  end

  // output shifter, updated on falling serial clock
  logic [7:0] out_sr_reg;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      out_sr_reg <= 8'h00;
    else if (sck_fall && bit_pos_reg == 3'h0 && state_reg == seprd_pkg::ST_READ)
      out_sr_reg <= pop_valid ? buf_mem[buf_rd_ptr_reg] : 8'h00;
    else if (sck_fall && bit_pos_reg == 3'h0 && state_reg == seprd_pkg::ST_STAT)
      out_sr_reg <= status_byte;
    else if (sck_fall)
      out_sr_reg <= {out_sr_reg[6:0], 1'b0};
  end

  // enable rises on the first falling edge of a data phase
  logic drive_reg;
  always_ff @(posedge ref_clk)
  begin
    if (srst || cs_n_s)
      drive_reg <= 1'b0;
    else if (sck_fall)
      drive_reg <= state_reg == seprd_pkg::ST_READ || state_reg == seprd_pkg::ST_STAT;
  end

  assign so_out = out_sr_reg[7];
  assign so_oe  = drive_reg && !held_reg && !cs_n_s;
  assign busy   = wr_busy_reg;
  assign write_enable_latch = write_enable_latch_reg;

  // checks
  // driver register itself must drop, not only the gated enable
  a_select_release: assert property (@(posedge ref_clk) disable iff (srst)
    cs_rise |=> !drive_reg && !so_oe) else $error("output driven after deselect");
  // pause seen on the synced pins must release the output one cycle later
  a_pause_release: assert property (@(posedge ref_clk) disable iff (srst)
    !hold_n_s && !sck_s && !cs_n_s |=> !so_oe) else $error("output driven during pause");
  a_pause_position: assert property (@(posedge ref_clk) disable iff (srst)
    held_reg && !cs_n_s ##1 held_reg && !cs_n_s |-> $stable(bit_pos_reg) && $stable(in_cnt_reg))
    else $error("bit position moved during pause");
  a_ptr_advance: assert property (@(posedge ref_clk) disable iff (srst)
    push && fetch_ptr_reg != TOP_ADDR |=> fetch_ptr_reg == $past(fetch_ptr_reg) + ADDR_BITS'(1))
    else $error("read pointer did not advance");
  a_ptr_wrap: assert property (@(posedge ref_clk) disable iff (srst)
    push && !addr_done && fetch_ptr_reg == TOP_ADDR |=> fetch_ptr_reg == '0)
    else $error("read pointer did not wrap");

  sequence s_addr_last;
    addr_done && opcode_reg == seprd_pkg::OP_ARRAY_READ;
  endsequence
  sequence s_first_fall;
    state_reg == seprd_pkg::ST_READ && sck_fall && bit_pos_reg == 3'h0 && pop_valid;
  endsequence
  a_read_start: assert property (@(posedge ref_clk) disable iff (srst)
    s_addr_last |=> state_reg == seprd_pkg::ST_READ ##1 pop_valid)
    else $error("read data not ready after address");
  a_read_drive: assert property (@(posedge ref_clk) disable iff (srst)
    s_first_fall ##1 (!held_reg && !cs_n_s) |-> so_oe && so_out == $past(buf_mem[buf_rd_ptr_reg][7]))
    else $error("read byte msb not driven");
  a_status_msb: assert property (@(posedge ref_clk) disable iff (srst)
    state_reg == seprd_pkg::ST_STAT && sck_fall && bit_pos_reg == 3'h0
    |=> so_out == $past(status_byte[seprd_pkg::ST_PROTECT_PIN_EN]))
    else $error("status msb wrong");
  a_busy_status: assert property (@(posedge ref_clk) disable iff (srst)
    op_done && wr_busy_reg && in_byte == seprd_pkg::OP_STATUS_READ
    |=> state_reg == seprd_pkg::ST_STAT) else $error("status read refused while busy");
  a_busy_ignore: assert property (@(posedge ref_clk) disable iff (srst)
    op_done && wr_busy_reg && in_byte != seprd_pkg::OP_STATUS_READ && !cs_n_s
    |=> state_reg == seprd_pkg::ST_IGNORE) else $error("command taken while busy");
  a_bad_opcode: assert property (@(posedge ref_clk) disable iff (srst)
    op_done && !op_valid && !cs_n_s |=> state_reg == seprd_pkg::ST_IGNORE ##1 !so_oe)
    else $error("invalid opcode not ignored");
  a_write_start: assert property (@(posedge ref_clk) disable iff (srst)
    wr_start |=> wr_busy_reg && wr_timer_reg == TW'(WRITE_CYCLES))
    else $error("write cycle not started");
  a_latch_clear: assert property (@(posedge ref_clk) disable iff (srst)
    wr_finish |=> !write_enable_latch_reg && !wr_busy_reg)
    else $error("latch not cleared after write");
  a_reset_state: assert property (@(posedge ref_clk) disable iff (srst)
    $fell(srst) |-> !write_enable_latch_reg && !wr_busy_reg && state_reg == seprd_pkg::ST_IDLE)
    else $error("bad state after reset");
  a_fall_change: assert property (@(posedge ref_clk) disable iff (srst)
    $changed(so_out) |-> $past(sck_fall)) else $error("output changed off falling edge");
endmodule

// File: testbench/seprd_host.sv
// behavioural host serial master: select, clock, data and pause
`timescale 1ns/10ps
module seprd_host (
  input  wire logic ref_clk,     // system clock
  input  wire logic so_out,      // device data value
  input  wire logic so_oe,       // device data enable
  output logic      cs_n_pin,    // chip select, active low
  output logic      sck_pin,     // serial clock, low outside frames
  output logic      si_pin,      // serial data to device
  output logic      hold_n_pin,  // pause, active low
  output logic      oe_seen      // device drove data in this frame
);
  localparam int HALF = 10;
  logic pat = 1'b0;
  logic so_line;

  // a released line shows a changing pattern, never the last bit
  always @(posedge ref_clk) pat <= ~pat;
  assign so_line = so_oe ? so_out : pat;

  initial
  begin
    cs_n_pin   = 1'b1;
    sck_pin    = 1'b0;
    si_pin     = 1'b0;
    hold_n_pin = 1'b1;
    oe_seen    = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // select moves only with the clock low, mode (0,0)
  task automatic sel(input logic v);
    wait_clk(4);
    if (!v)
      oe_seen = 1'b0;
    cs_n_pin = v;
    wait_clk(6);
  endtask

  // msb first, si set with sck low, so sampled on the rise
  task automatic bits_x(input logic [7:0] tx, input int hi, input int lo,
                        output logic [7:0] rx);
    rx = 8'h00;
    for (int i = hi; i >= lo; i--)
    begin
      si_pin = tx[i];
      wait_clk(HALF);
      sck_pin = 1'b1;
      rx[i] = so_line;
      if (so_oe)
        oe_seen = 1'b1;
      wait_clk(HALF);
      sck_pin = 1'b0;
    end
  endtask

  // pause with sck low, select held low, clock and data wiggled meanwhile
  task automatic pause(output logic drv);
    drv = 1'b0;
    // let the clock's fall settle first so pause never races it
    wait_clk(2);
    hold_n_pin = 1'b0;
    wait_clk(HALF);
    repeat (2)
    begin
      si_pin = ~si_pin;
      wait_clk(HALF);
      sck_pin = 1'b1;
      if (so_oe)
        drv = 1'b1;
      wait_clk(HALF);
      sck_pin = 1'b0;
    end
    hold_n_pin = 1'b1;
    wait_clk(HALF);
  endtask
endmodule

// File: testbench/seprd_core_tb.sv
// self-checking bench for the serial eeprom read and pause logic
`timescale 1ns/10ps
module seprd_core_tb;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] nd;
    logic [7:0] rx;
    logic       latch;
    logic       oe;
  } seprd_row_t;

  logic        ref_clk;
  logic        srst;
  logic        cs_n_pin;
  logic        sck_pin;
  logic        si_pin;
  logic        hold_n_pin;
  logic        so_out;
  logic        so_oe;
  logic        busy;
  logic        write_enable_latch;
  logic        oe_seen;
  logic        drv;
  logic [7:0]  r1;
  logic [7:0]  r2;
  logic [15:0] rx;
  int          num_errors;
  int          num_checks;
  seprd_row_t  rows [5];

  // short write cycle keeps the run brief, long enough to poll status
  seprd_core #(.WRITE_CYCLES(2000)) u_seprd_core (
    .ref_clk(ref_clk), .srst(srst), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
    .si_pin(si_pin), .hold_n_pin(hold_n_pin), .so_out(so_out), .so_oe(so_oe),
    .busy(busy), .write_enable_latch(write_enable_latch)
  );

  seprd_host u_seprd_host (
    .ref_clk(ref_clk), .so_out(so_out), .so_oe(so_oe), .cs_n_pin(cs_n_pin),
    .sck_pin(sck_pin), .si_pin(si_pin), .hold_n_pin(hold_n_pin), .oe_seen(oe_seen)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic frame(input logic [7:0] op, input bit adr_en, input logic [15:0] adr,
                       input int nd, input logic [7:0] dat);
    logic [7:0] r;
    u_seprd_host.sel(1'b0);
    u_seprd_host.bits_x(op, 7, 0, r);
    if (adr_en)
    begin
      u_seprd_host.bits_x(adr[15:8], 7, 0, r);
      u_seprd_host.bits_x(adr[7:0], 7, 0, r);
    end
    rx = 16'h0000;
    for (int i = 0; i < nd; i++)
    begin
      u_seprd_host.bits_x(dat, 7, 0, r);
      rx = {rx[7:0], r};
    end
    u_seprd_host.sel(1'b1);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 3000)
      check(16'h0001, 16'h0000);
  endtask

  task automatic do_reset();
    srst = 1'b1;
    repeat (10) @(negedge ref_clk);
    srst = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask

  initial
  begin
    #600000;
    num_errors++;
    test_done();
  end

  initial
  begin
    srst = 1'b1;
    num_errors = 0;
    num_checks = 0;
    rows[0] = {8'h06, 8'h00, 8'h00, 1'b1, 1'b0};
    rows[1] = {8'h05, 8'h01, 8'h02, 1'b1, 1'b1};
    rows[2] = {8'h04, 8'h00, 8'h00, 1'b0, 1'b0};
    rows[3] = {8'h05, 8'h01, 8'h00, 1'b0, 1'b1};
    rows[4] = {8'hFF, 8'h01, 8'h00, 1'b0, 1'b0};
    do_reset();
    check({13'h0, so_oe, busy, write_enable_latch}, 16'h0000);
    $display("test reset done");
    foreach (rows[i])
    begin
      frame(rows[i].op, 1'b0, 16'h0000, int'(rows[i].nd), 8'h00);
      check({15'h0, write_enable_latch}, {15'h0, rows[i].latch});
      check({15'h0, oe_seen}, {15'h0, rows[i].oe});
      if (rows[i].oe)
        check(rx, {8'h00, rows[i].rx});
    end
    $display("test command table done");
    frame(8'h06, 1'b0, 16'h0000, 0, 8'h00);
    frame(8'h01, 1'b0, 16'h0000, 1, 8'h8C);
    check({15'h0, busy}, 16'h0001);
    frame(8'h05, 1'b0, 16'h0000, 2, 8'h00);
    check(rx, 16'h0303);
    wait_idle();
    frame(8'h05, 1'b0, 16'h0000, 1, 8'h00);
    check(rx, 16'h008C);
    $display("test status write done");
    frame(8'h06, 1'b0, 16'h0000, 0, 8'h00);
    frame(8'h02, 1'b1, 16'hFFFF, 1, 8'hA5);
    frame(8'h03, 1'b1, 16'h0000, 1, 8'h00);
    check({15'h0, oe_seen}, 16'h0000);
    wait_idle();
    check({15'h0, write_enable_latch}, 16'h0000);
    frame(8'h06, 1'b0, 16'h0000, 0, 8'h00);
    frame(8'h02, 1'b1, 16'h0000, 1, 8'h5A);
    wait_idle();
    // the wrap read prefetches one byte past its end: give it known data
    frame(8'h06, 1'b0, 16'h0000, 0, 8'h00);
    frame(8'h02, 1'b1, 16'h0001, 1, 8'hC3);
    wait_idle();
    $display("test array write done");
    // upper address bits differ from the write: only 13 bits count
    frame(8'h03, 1'b1, 16'h3FFF, 2, 8'h00);
    check(rx, 16'hA55A);
    check({15'h0, so_oe}, 16'h0000);
    $display("test read wrap done");
    u_seprd_host.sel(1'b0);
    u_seprd_host.bits_x(8'h03, 7, 0, r1);
    u_seprd_host.bits_x(8'h1F, 7, 0, r1);
    u_seprd_host.bits_x(8'hFF, 7, 0, r1);
    u_seprd_host.bits_x(8'h00, 7, 4, r1);
    u_seprd_host.pause(drv);
    u_seprd_host.bits_x(8'h00, 3, 0, r2);
    u_seprd_host.sel(1'b1);
    check({15'h0, drv}, 16'h0000);
    check({8'h00, r1 | r2}, 16'h00A5);
    $display("test pause done");
    frame(8'h06, 1'b0, 16'h0000, 0, 8'h00);
    check({15'h0, write_enable_latch}, 16'h0001);
    do_reset();
    check({15'h0, write_enable_latch}, 16'h0000);
    $display("test second reset done");
    test_done();
  end
endmodule
